// ===== design/atpg_pkg.sv
package atpg_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_CONTROL   = 12'h550;
    localparam logic [11:0] IDX_USER_BASE = 12'h551;
    localparam logic [11:0] IDX_USER_LAST = 12'h558;
    localparam int          ADDR_W        = 14;
    localparam int          SAMPLE_W      = 16;
    localparam int          USER_BYTES    = 8;
    localparam int          UIDX_W        = 3;

    // Control field positions and reset
    localparam int          BIT_PLAY_ONCE = 7;
    localparam int          BIT_RSV       = 6;
    localparam int          BIT_LONG_RST  = 5;
    localparam int          BIT_SHORT_RST = 4;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  CONTROL_WMASK = 8'hbf;
    localparam logic [7:0]  USER_RESET    = 8'h00;

    // Fixed output words, offset binary
    localparam logic [15:0] WORD_MID      = 16'h8000;
    localparam logic [15:0] WORD_POS_FS   = 16'hffff;
    localparam logic [15:0] WORD_NEG_FS   = 16'h0000;
    localparam logic [15:0] WORD_CHECKER  = 16'haaaa;
    localparam logic [15:0] WORD_ONES     = 16'hffff;
    localparam logic [15:0] WORD_ZEROS    = 16'h0000;

    // Generator seeds, plain defaults
    localparam logic [22:0] LONG_SEED     = 23'h7fffff;
    localparam logic [8:0]  SHORT_SEED    = 9'h1ff;

    typedef enum logic [3:0] {
        ATPG_OFF      = 4'b0000,
        ATPG_MID      = 4'b0001,
        ATPG_POS_FS   = 4'b0010,
        ATPG_NEG_FS   = 4'b0011,
        ATPG_CHECKER  = 4'b0100,
        ATPG_LONG_SEQ = 4'b0101,
        ATPG_SHORT_SEQ= 4'b0110,
        ATPG_TOGGLE   = 4'b0111,
        ATPG_USER     = 4'b1000
    } atpg_mode_type;

    typedef enum logic [1:0] {
        ATPG_PLAY_IDLE = 2'b00,
        ATPG_PLAY_RUN  = 2'b01,
        ATPG_PLAY_DONE = 2'b10
    } atpg_play_type;
endpackage

// ===== design/atpg_user_mem.sv
`timescale 1ns/10ps
module atpg_user_mem (
    input  wire logic                            mclk,    // Sample clock
    input  wire logic                            rst_n,   // Async reset, active low
    input  wire logic                            wr_en,   // Byte write strobe
    input  wire logic [atpg_pkg::UIDX_W-1:0]     wr_idx,  // Byte index
    input  wire logic [7:0]                      wr_data, // Byte value
    input  wire logic [atpg_pkg::UIDX_W-1:0]     rd_idx,  // Byte index for bus read
    output logic      [7:0]                      rd_data, // Registered read byte
    input  wire logic [1:0]                      pat_sel, // Pattern for playback
    output logic      [15:0]                     pat_word // Registered pattern word
);
    import atpg_pkg::*;

    logic [7:0] mem_q [USER_BYTES];

    // ============================================================
    // Storage
    genvar g;
    generate
        for (g = 0; g < USER_BYTES; g++) begin : g_byte
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[g] <= USER_RESET; // RULE9
                end else if (wr_en && wr_idx == UIDX_W'(g)) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // ============================================================
    // Registered reads
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= 8'h00;
            pat_word <= 16'h0000;
        end else begin
            rd_data  <= mem_q[rd_idx];
            pat_word <= {mem_q[{pat_sel, 1'b1}], mem_q[{pat_sel, 1'b0}]}; // RULE6
        end
    end
endmodule

// ===== design/atpg_gen.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// How it works
// RULE1: A four-bit mode field picks normal samples or a fixed level, checkerboard or word toggle.
// RULE2: Mode 1000 plays the four user patterns, once or repeating as the playback bit chooses.
// RULE3: The playback bit is looked at only in user-pattern mode and ignored otherwise.
// RULE4: With playback bit clear, patterns one to four each show one cycle and repeat forever.
// RULE5: With playback bit set, patterns one to four show once for one cycle each, then zeros.
// RULE6: Each pattern is a low byte at the lower address and high byte at the next, in order.
// RULE7: Mode 0101 outputs the long random sequence, whose generator bit 5 holds in reset.
// RULE8: Mode 0110 outputs the short random sequence, whose generator bit 4 holds in reset.
// RULE9: Each user pattern is sixteen bits from two writable bytes that reset to zero.
// RULE10: The test word replaces the sample word in place, so the framer sees it in its slot; the code strobes test words every cycle, whatever sample_valid is.
module atpg_gen (
    input  wire logic                          mclk,              // 20 MHz sample clock
    input  wire logic                          rst_n,             // Async reset, active low
    input  wire logic [atpg_pkg::ADDR_W-1:0]   avs_address,       // Byte address
    input  wire logic                          avs_read,          // Read request
    input  wire logic                          avs_write,         // Write request
    input  wire logic [31:0]                   avs_writedata,     // Write data
    input  wire logic [3:0]                    avs_byteenable,    // Byte enables
    output logic      [31:0]                   avs_readdata,      // Read data
    output logic                               avs_waitrequest,   // Stall
    input  wire logic [atpg_pkg::SAMPLE_W-1:0] sample_in,         // Converter sample
    input  wire logic                          sample_valid,      // Sample strobe
    output logic      [atpg_pkg::SAMPLE_W-1:0] sample_out,        // Word to formatter
    output logic                               sample_out_valid   // Word strobe
);
    import atpg_pkg::*;

    // ============================================================
    // Bus slave: two wait cycles, so memory read and bus read data both come from flops
    logic [7:0]  control_q;
    logic        stage_q;
    logic [11:0] idx;
    logic        sel_ctrl;
    logic        sel_user;
    logic        wr_fire;
    logic [7:0]  mem_rd;
    logic [15:0] user_word;

    assign idx      = avs_address[ADDR_W-1:2];
    assign sel_ctrl = (idx == IDX_CONTROL);
    assign sel_user = (idx >= IDX_USER_BASE) && (idx <= IDX_USER_LAST);
    assign wr_fire  = avs_write && !avs_waitrequest && avs_byteenable[0];

    function automatic logic [UIDX_W-1:0] user_slot(input logic [11:0] i);
        logic [11:0] d;
        d = i - IDX_USER_BASE;
        return d[UIDX_W-1:0];
    endfunction

    // Second cycle of a request; the stall drops on the cycle after it
    // A back-to-back request is seen only after the stall has risen again
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= 1'b0;
        end else begin
            stage_q <= (avs_read || avs_write) && avs_waitrequest && !stage_q;
        end
    end

    // The stall is a flop, so the master never sees a path through this block;
    // the price is a second wait cycle on every access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (stage_q) begin
            avs_waitrequest <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= CONTROL_RESET;
        end else if (wr_fire && sel_ctrl) begin
            control_q <= avs_writedata[7:0] & CONTROL_WMASK;
        end
    end

    // Unmapped indices read as zero
    function automatic logic [31:0] read_word(input logic is_ctrl, input logic is_user,
        input logic [7:0] ctrl_v, input logic [7:0] user_v);
        return is_ctrl ? {24'h000000, ctrl_v} : is_user ? {24'h000000, user_v} : 32'h0000_0000;
    endfunction

    // Loaded on the same edge that the stall drops, then held while the master takes them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (stage_q && avs_read) begin
            avs_readdata <= read_word(sel_ctrl, sel_user, control_q, mem_rd);
        end
    end

    // ============================================================
    // User playback sequencer
    atpg_mode_type mode;
    atpg_play_type play_q;
    logic [1:0]    pat_q;
    logic          play_once;

    assign mode      = atpg_mode_type'(control_q[3:0]);
    assign play_once = control_q[BIT_PLAY_ONCE]; // RULE3

    atpg_user_mem u_mem (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (wr_fire && sel_user),
        .wr_idx   (user_slot(idx)),
        .wr_data  (avs_writedata[7:0]),
        .rd_idx   (user_slot(idx)),
        .rd_data  (mem_rd),
        .pat_sel  (pat_q),
        .pat_word (user_word)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            play_q <= ATPG_PLAY_IDLE;
            pat_q  <= 2'b00;
        end else if (mode != ATPG_USER) begin
            play_q <= ATPG_PLAY_IDLE;
            pat_q  <= 2'b00;
        end else begin
            case (play_q)
                ATPG_PLAY_IDLE: begin
                    play_q <= ATPG_PLAY_RUN; // RULE2
                    pat_q  <= 2'b01;
                end
                ATPG_PLAY_RUN: begin
                    pat_q <= pat_q + 2'b01; // RULE4
                    if (pat_q == 2'b00 && play_once) begin
                        play_q <= ATPG_PLAY_DONE; // RULE5
                    end
                end
                ATPG_PLAY_DONE: begin
                    play_q <= ATPG_PLAY_DONE;
                end
                default: begin
                    play_q <= ATPG_PLAY_IDLE;
                end
            endcase
        end
    end
    // The pattern word lags pat_q by one cycle through the memory register
    logic play_live_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            play_live_q <= 1'b0;
        end else begin
            // In a single pass the gate closes with pattern four,
            // otherwise pattern one would leak out once more
            play_live_q <= (mode == ATPG_USER) && (play_q != ATPG_PLAY_DONE)
                           && !(play_q == ATPG_PLAY_RUN && pat_q == 2'b00 && play_once); // RULE5
        end
    end

    // ============================================================
    // Pseudorandom generators, free running unless held in reset
    logic [22:0] long_q;
    logic [8:0]  short_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            long_q <= LONG_SEED;
        end else if (control_q[BIT_LONG_RST]) begin
            long_q <= LONG_SEED; // RULE7
        end else begin
            long_q <= {long_q[21:0], long_q[22] ^ long_q[17]};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            short_q <= SHORT_SEED;
        end else if (control_q[BIT_SHORT_RST]) begin
            short_q <= SHORT_SEED; // RULE8
        end else begin
            short_q <= {short_q[7:0], short_q[8] ^ short_q[4]};
        end
    end

    // ============================================================
    // Output selection
    logic        toggle_q;
    logic [15:0] word_d;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= !toggle_q;
        end
    end

    always_comb begin
        case (mode)
            ATPG_OFF:       word_d = sample_in;
            ATPG_MID:       word_d = WORD_MID; // RULE1
            ATPG_POS_FS:    word_d = WORD_POS_FS;
            ATPG_NEG_FS:    word_d = WORD_NEG_FS;
            ATPG_CHECKER:   word_d = toggle_q ? ~WORD_CHECKER : WORD_CHECKER;
            ATPG_LONG_SEQ:  word_d = long_q[15:0]; // RULE7
            ATPG_SHORT_SEQ: word_d = {short_q[7:0], short_q[8:1]}; // RULE8
            ATPG_TOGGLE:    word_d = toggle_q ? WORD_ZEROS : WORD_ONES;
            ATPG_USER:      word_d = play_live_q ? user_word : WORD_ZEROS; // RULE5
            default:        word_d = sample_in;
        endcase
    end

    // Test words are strobed every cycle whatever sample_valid is, so they fill every slot
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_out       <= 16'h0000;
            sample_out_valid <= 1'b0;
        end else begin
            sample_out       <= word_d; // RULE10
            sample_out_valid <= sample_valid || (mode != ATPG_OFF);
        end
    end
endmodule

// ===== verification/atpg_fmt_sink.sv
`timescale 1ns/10ps
// ==========
// Formatter stand-in: takes every strobed word, as the framer would
module atpg_fmt_sink (
    input  wire logic        mclk,   // Sample clock
    input  wire logic        rst_n,  // Async reset, active low
    input  wire logic [15:0] word,   // Word from generator
    input  wire logic        valid,  // Word strobe
    output logic      [15:0] last_q, // Last word taken
    output logic      [31:0] count_q // Words taken
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_q  <= 16'h0000;
            count_q <= 32'h0;
        end else if (valid) begin
            last_q  <= word;
            count_q <= count_q + 32'h1;
        end
    end
endmodule

// ===== verification/atpg_gen_asserts.sv
`timescale 1ns/10ps
module atpg_gen_asserts
    import atpg_pkg::*;
(
    input wire logic                mclk,             // Clock
    input wire logic                rst_n,            // Reset
    input wire logic [ADDR_W-1:0]   avs_address,      // Address
    input wire logic                avs_read,         // Read
    input wire logic                avs_write,        // Write
    input wire logic [31:0]         avs_writedata,    // Write data
    input wire logic [3:0]          avs_byteenable,   // Byte enables
    input wire logic [31:0]         avs_readdata,     // Read data
    input wire logic                avs_waitrequest,  // Stall
    input wire logic [SAMPLE_W-1:0] sample_in,        // Sample
    input wire logic                sample_valid,     // Sample strobe
    input wire logic [SAMPLE_W-1:0] sample_out,       // Output word
    input wire logic                sample_out_valid  // Output strobe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Shadow of the control byte; checks wait until a mode has settled
    logic [7:0] ctl_q;
    logic [2:0] st_q;
    logic       on;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            st_q  <= 3'h0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                     && avs_address[13:2] == IDX_CONTROL) begin
            ctl_q <= avs_writedata[7:0];
            st_q  <= 3'h0;
        end else if (st_q != 3'h7) begin
            st_q <= st_q + 3'h1;
        end
    end
    assign on = (st_q >= 3'h5);
    // ==========
    // Bus and output checks
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("no answer");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    rsv_bit_a: assert property (avs_read && !avs_waitrequest
        && avs_address[13:2] == IDX_CONTROL |-> avs_readdata[31:6] == 26'h0
        || avs_readdata[31:6] == 26'h2) else $error("reserved bit set");
    pass_thru_a: assert property (on && ctl_q[3:0] == 4'h0
        |-> sample_out == $past(sample_in) && sample_out_valid == $past(sample_valid))
        else $error("samples not passed");
    fixed_word_a: assert property (on && ctl_q[3:0] inside {4'h1, 4'h2, 4'h3}
        |-> sample_out == (ctl_q[1:0] == 2'h1 ? WORD_MID : ctl_q[1:0] == 2'h2
        ? WORD_POS_FS : WORD_NEG_FS)) else $error("fixed word wrong");
    checker_alt_a: assert property (on && ctl_q[3:0] == 4'h4
        |-> sample_out inside {16'haaaa, 16'h5555} && $changed(sample_out))
        else $error("checkerboard wrong");
    word_toggle_a: assert property (on && ctl_q[3:0] == 4'h7
        |-> sample_out inside {16'hffff, 16'h0000} && sample_out == ~$past(sample_out))
        else $error("toggle wrong");
    long_held_a: assert property (on && ctl_q[3:0] == 4'h5 && ctl_q[5]
        |-> $stable(sample_out)) else $error("long sequence not held");
    short_held_a: assert property (on && ctl_q[3:0] == 4'h6 && ctl_q[4]
        |-> $stable(sample_out)) else $error("short sequence not held");
    test_valid_a: assert property (on && ctl_q[3:0] inside {[4'h1:4'h8]}
        |-> sample_out_valid) else $error("test word not strobed");
endmodule

bind atpg_gen atpg_gen_asserts u_chk (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_in,
    .sample_valid, .sample_out, .sample_out_valid);

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import atpg_pkg::*;
    logic        mclk, rst_n, avs_read, avs_write, sample_valid, avs_waitrequest, sample_out_valid;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, sink_cnt, cnt0, r;
    logic [3:0]  avs_byteenable;
    logic [15:0] sample_in, sample_out, sink_last, a, b;
    logic [15:0] pat [4];
    logic [3:0]  codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    logic [7:0]  rd;
    logic [31:0] seed = 32'hc6e3193c;
    int          n_fail = 0, checks_done = 0, cyc = 0, n;

    atpg_gen dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_in, .sample_valid,
        .sample_out, .sample_out_valid);
    atpg_fmt_sink sink (.mclk, .rst_n, .word(sample_out), .valid(sample_out_valid),
        .last_q(sink_last), .count_q(sink_cnt));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    // ==========
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] fixw(input logic [3:0] m, input logic [15:0] p);
        case (m)
            4'h1: return WORD_MID;
            4'h2: return WORD_POS_FS;
            4'h3: return WORD_NEG_FS;
            4'h4: return (p == 16'haaaa) ? 16'h5555 : 16'haaaa;
            default: return (p == WORD_ONES) ? WORD_ZEROS : WORD_ONES;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request stands until the stall is seen low at a rising edge, then is dropped
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, wd};
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic setm(input logic [7:0] c);
        bus(1'b1, IDX_CONTROL, c);
        repeat (6) @(posedge mclk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // Sequence
    initial begin
        {rst_n, avs_read, avs_write, sample_valid} = 4'h0;
        avs_address = 14'h0000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        sample_in = 16'h0000;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, IDX_CONTROL + 12'(i), 8'h00);
            chk("reset value", 16'h0000, {8'h00, rd});
        end
        bus(1'b1, IDX_CONTROL, 8'hff);
        bus(1'b0, IDX_CONTROL, 8'h00);
        chk("control", {8'h00, CONTROL_WMASK}, {8'h00, rd});
        bus(1'b1, 12'h559, 8'h5a);
        bus(1'b0, 12'h559, 8'h00);
        chk("unmapped", 16'h0000, {8'h00, rd});
        for (int k = 0; k < 4; k++) begin
            r = xs();
            pat[k] = r[15:0] | 16'h0004;
            pat[k][1:0] = 2'(k);
            bus(1'b1, IDX_USER_BASE + 12'(2 * k), pat[k][7:0]);
            bus(1'b1, IDX_USER_BASE + 12'(2 * k + 1), pat[k][15:8]);
        end
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, IDX_USER_BASE + 12'(k), 8'h00);
            chk("user byte", {8'h00, pat[k / 2][8 * (k % 2) +: 8]}, {8'h00, rd});
        end
        setm(8'h00);
        for (int i = 0; i < 16; i++) begin
            r = xs();
            sample_in <= r[15:0];
            sample_valid <= r[16];
            @(posedge mclk);
            @(negedge mclk);
            chk("sample", r[15:0], sample_out);
            chk("strobe", {15'h0, r[16]}, {15'h0, sample_out_valid});
            @(posedge mclk);
        end
        // Bit 7 is set at random here, so an unused play bit must change nothing
        for (int i = 0; i < 5; i++) begin
            r = xs();
            setm({r[0], 3'b000, codes[i]});
            @(negedge mclk);
            a = sample_out;
            cnt0 = sink_cnt;
            @(negedge mclk);
            b = sample_out;
            chk("taken word", a, sink_last);
            chk("fixed", fixw(codes[i], a), b);
            chk("fixed", fixw(codes[i], b), a);
            repeat (7) @(negedge mclk);
            chk("words taken", cnt0[15:0] + 16'h8, sink_cnt[15:0]);
            @(posedge mclk);
        end
        for (int i = 0; i < 2; i++) begin
            setm(i ? 8'h16 : 8'h25);
            @(negedge mclk);
            a = sample_out;
            @(negedge mclk);
            chk("held", a, sample_out);
            @(posedge mclk);
            setm(i ? 8'h06 : 8'h05);
            @(negedge mclk);
            a = sample_out;
            @(negedge mclk);
            chk("running", 16'h0001, {15'h0, a !== sample_out});
            @(posedge mclk);
        end
        for (int u = 0; u < 2; u++) begin
            setm(8'h00);
            bus(1'b1, IDX_CONTROL, u ? 8'h88 : 8'h08);
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (sample_out !== pat[0] && n < 12);
            chk("first pattern", pat[0], sample_out);
            for (int j = 1; j < 9; j++) begin
                @(negedge mclk);
                chk("pattern", (u == 0 || j < 4) ? pat[j % 4] : 16'h0000, sample_out);
            end
            @(posedge mclk);
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, IDX_CONTROL, 8'h00);
        chk("second reset", 16'h0000, {8'h00, rd});
        complete_run();
    end
endmodule
